// ---- rtl/eiv_defines.vh ----
`ifndef EIV_DEFINES_VH
`define EIV_DEFINES_VH
// ---------------------------------------------------------------
// register indices (byte addresses on the plain port)
// ---------------------------------------------------------------
`define EIV_ADDR_W          4
`define EIV_REG_PLACEMENT   4'h0
`define EIV_REG_SENSE       4'h1
`define EIV_REG_IRQ_ENABLE  4'h2
`define EIV_REG_IRQ_FLAG    4'h3
`define EIV_REG_PC_ENABLE   4'h4
`define EIV_REG_PC_FLAG     4'h5
`define EIV_REG_PC_MASK0    4'h6
`define EIV_REG_PC_MASK1    4'h7
`define EIV_REG_PC_MASK2    4'h8
`define EIV_REG_STATUS      4'h9
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define EIV_BIT_UNLOCK      0
`define EIV_BIT_VSEL        1
`define EIV_BIT_GIE         7
// ---------------------------------------------------------------
// sense codes
// ---------------------------------------------------------------
`define EIV_SENSE_LOW       2'b00
`define EIV_SENSE_ANY       2'b01
`define EIV_SENSE_FALL      2'b10
`define EIV_SENSE_RISE      2'b11
// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define EIV_RESET_BYTE      8'h00
`define EIV_UNLOCK_CYCLES   3'h4
`define EIV_PC_MASK1_USED   8'h7F
`endif

// ---- rtl/eiv_ext_irq.v ----
`timescale 1ns/10ps
`include "eiv_defines.vh"
// What this block does
// - vector base zero or boot start
// - unlock clears after four or select write
// - block interrupts during unlock sequence
// - blocking leaves global enable untouched
// - boot locks block interrupts by section
// - pins trigger even when driven as outputs
// - three pin-change groups by pin ranges
// - per-group masks gate individual pins
// - pin-change detection runs on clock through the synchronisers
// - level mode requests while pin low
// - edge detection runs on clock
// - low level detected on clock through the synchronisers
// - level vanishing before start-up gives nothing
// - pin one sense code selects trigger
// - sample pin first, longer pulses caught
// - take only with global and own enable
// - sense register upper nibble reads zero
// - pin zero sense uses same code
// - pin flags set on edge, write-one clear
// - group flags set on change, write-one clear
module eiv_ext_irq
#(
   parameter VEC_W = 14
)
(
   input  wire             clock,
   input  wire             rst,
   input  wire [3:0]       addr,
   input  wire [7:0]       wdata,
   input  wire             wr,
   input  wire             rd,
   output reg  [7:0]       rdata,
   input  wire [1:0]       ext_irq_pin,
   input  wire [23:0]      pin_change_inputs,
   input  wire             cpu_status_word_gie,
   input  wire [1:0]       ack_ext,
   input  wire [2:0]       ack_pc,
   input  wire [VEC_W-1:0] boot_start_addr,
   input  wire             app_side_boot_lock,
   input  wire             boot_side_boot_lock,
   input  wire             exec_in_boot,
   output reg  [VEC_W-1:0] vector_base,
   output reg  [1:0]       take_ext,
   output reg  [2:0]       take_pc,
   output reg  [1:0]       level_wake,
   output reg  [2:0]       pc_wake,
   output reg              irq_blocked
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   reg [1:0]  ext_sync1;
   reg [1:0]  ext_sync2;
   reg [1:0]  ext_prev;
   reg [23:0] pc_sync1;
   reg [23:0] pc_sync2;
   reg [23:0] pc_prev;
   reg [3:0]  sense;
   reg [1:0]  ext_enable;
   reg [1:0]  ext_flag;
   reg [2:0]  pc_enable;
   reg [2:0]  pc_flag;
   reg [7:0]  pc_mask0;
   reg [6:0]  pc_mask1;
   reg [7:0]  pc_mask2;
   reg        vector_base_select;
   reg        vector_change_unlock;
   reg [2:0]  unlock_count;
   reg        hold_after_select;
   wire       write_place;
   wire       write_sel_ok;
   wire [1:0] ext_fire;
   wire [1:0] ext_level;
   wire [23:0] pc_masked_change;
   wire [2:0] pc_fire;
   wire       lock_block;
   wire       seq_block;
   reg  [7:0] next_rdata;
   genvar     g;

   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   // pins pass two flops; prev holds the older synced sample
   // dedicated pins idle high, so their stages reset high: no false edge or level after reset
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         ext_sync1 <= 2'h3;
         ext_sync2 <= 2'h3;
         ext_prev  <= 2'h3;
         pc_sync1  <= 24'h00_0000;
         pc_sync2  <= 24'h00_0000;
         pc_prev   <= 24'h00_0000;
      end
      else
      begin
         ext_sync1 <= ext_irq_pin;
         ext_sync2 <= ext_sync1;
         ext_prev  <= ext_sync2;
         pc_sync1  <= pin_change_inputs;
         pc_sync2  <= pc_sync1;
         pc_prev   <= pc_sync2;
      end
   end

   // ---------------------------------------------------------------
   // dedicated pin trigger decode
   // ---------------------------------------------------------------
   // both pins share one sense encoding, so one generate loop serves both
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : g_ext
         wire [1:0] mode = sense[2*g+1:2*g];
         wire rise = ext_sync2[g] & ~ext_prev[g];
         wire fall = ~ext_sync2[g] & ext_prev[g];
         assign ext_fire[g] = (mode == `EIV_SENSE_ANY)  ? (rise | fall) :
                              (mode == `EIV_SENSE_FALL) ? fall :
                              (mode == `EIV_SENSE_RISE) ? rise : 1'b0;
         // level request follows the synced level, no flag kept
         assign ext_level[g] = (mode == `EIV_SENSE_LOW) & ~ext_sync2[g];
      end
   endgenerate

   // ---------------------------------------------------------------
   // pin-change group decode
   // ---------------------------------------------------------------
   assign pc_masked_change = (pc_sync2 ^ pc_prev) & {pc_mask2, 1'b0, pc_mask1, pc_mask0};
   assign pc_fire[0] = |pc_masked_change[7:0];
   assign pc_fire[1] = |pc_masked_change[14:8];
   assign pc_fire[2] = |pc_masked_change[23:16];

   // ---------------------------------------------------------------
   // vector-select unlock sequence
   // ---------------------------------------------------------------
   assign write_place  = wr & (addr == `EIV_REG_PLACEMENT);
   assign write_sel_ok = write_place & vector_change_unlock & ~wdata[`EIV_BIT_UNLOCK];
   // section lock: vectors away from the running section are unusable
   assign lock_block   = (vector_base_select & app_side_boot_lock & ~exec_in_boot) |
                         (~vector_base_select & boot_side_boot_lock & exec_in_boot);
   assign seq_block    = vector_change_unlock | hold_after_select;

   // software is trusted to finish within the window; late writes are dropped
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         vector_base_select   <= 1'b0;
         vector_change_unlock <= 1'b0;
         unlock_count         <= 3'h0;
         hold_after_select    <= 1'b0;
      end
      else
      begin
         hold_after_select <= 1'b0;
         if (write_sel_ok)
         begin
            vector_base_select   <= wdata[`EIV_BIT_VSEL];
            vector_change_unlock <= 1'b0;
            hold_after_select    <= 1'b1;
         end
         else if (write_place & wdata[`EIV_BIT_UNLOCK])
         begin
            vector_change_unlock <= 1'b1;
            unlock_count         <= `EIV_UNLOCK_CYCLES - 3'h1;
         end
         else if (vector_change_unlock)
         begin
            if (unlock_count == 3'h0)
               vector_change_unlock <= 1'b0;
            else
               unlock_count <= unlock_count - 3'h1;
         end
      end
   end

   // ---------------------------------------------------------------
   // control registers and flags
   // ---------------------------------------------------------------
   // set beats write-one clear and acknowledge
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         sense      <= 4'h0;
         ext_enable <= 2'h0;
         ext_flag   <= 2'h0;
         pc_enable  <= 3'h0;
         pc_flag    <= 3'h0;
         pc_mask0   <= 8'h00;
         pc_mask1   <= 7'h00;
         pc_mask2   <= 8'h00;
      end
      else
      begin
         if (wr & (addr == `EIV_REG_SENSE))
            sense <= wdata[3:0];
         if (wr & (addr == `EIV_REG_IRQ_ENABLE))
            ext_enable <= wdata[1:0];
         if (wr & (addr == `EIV_REG_PC_ENABLE))
            pc_enable <= wdata[2:0];
         if (wr & (addr == `EIV_REG_PC_MASK0))
            pc_mask0 <= wdata;
         if (wr & (addr == `EIV_REG_PC_MASK1))
            pc_mask1 <= wdata[6:0];
         if (wr & (addr == `EIV_REG_PC_MASK2))
            pc_mask2 <= wdata;
         ext_flag <= ext_fire |
                     (ext_flag & ~ack_ext &
                      ~((wr & (addr == `EIV_REG_IRQ_FLAG)) ? wdata[1:0] : 2'h0) &
                      ~{sense[3:2] == `EIV_SENSE_LOW, sense[1:0] == `EIV_SENSE_LOW});
         pc_flag  <= pc_fire |
                     (pc_flag & ~ack_pc &
                      ~((wr & (addr == `EIV_REG_PC_FLAG)) ? wdata[2:0] : 3'h0));
      end
   end

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   always @*
   begin
      case (addr)
         `EIV_REG_PLACEMENT:  next_rdata = {6'h00, vector_base_select, vector_change_unlock};
         `EIV_REG_SENSE:      next_rdata = {4'h0, sense};
         `EIV_REG_IRQ_ENABLE: next_rdata = {6'h00, ext_enable};
         `EIV_REG_IRQ_FLAG:   next_rdata = {6'h00, ext_flag};
         `EIV_REG_PC_ENABLE:  next_rdata = {5'h00, pc_enable};
         `EIV_REG_PC_FLAG:    next_rdata = {5'h00, pc_flag};
         `EIV_REG_PC_MASK0:   next_rdata = pc_mask0;
         `EIV_REG_PC_MASK1:   next_rdata = {1'b0, pc_mask1};
         `EIV_REG_PC_MASK2:   next_rdata = pc_mask2;
         `EIV_REG_STATUS:     next_rdata = {irq_blocked, 2'h0, ext_sync2, level_wake, 1'b0};
         default:             next_rdata = 8'h00;
      endcase
   end

   // ---------------------------------------------------------------
   // registered outputs
   // ---------------------------------------------------------------
   // takes are gated by global enable and own enable; gie is only read
   always @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         rdata       <= 8'h00;
         vector_base <= {VEC_W{1'b0}};
         take_ext    <= 2'h0;
         take_pc     <= 3'h0;
         level_wake  <= 2'h0;
         pc_wake     <= 3'h0;
         irq_blocked <= 1'b0;
      end
      else
      begin
         rdata       <= rd ? next_rdata : 8'h00;
         vector_base <= vector_base_select ? boot_start_addr : {VEC_W{1'b0}};
         irq_blocked <= seq_block | lock_block | (write_place & wdata[`EIV_BIT_UNLOCK]);
         take_ext    <= (ext_flag | ext_level) & ext_enable &
                        {2{cpu_status_word_gie & ~seq_block & ~lock_block}};
         take_pc     <= pc_flag & pc_enable &
                        {3{cpu_status_word_gie & ~seq_block & ~lock_block}};
         // wake hints: level and change requests, shown for the sleep controller
         level_wake  <= ext_level & ext_enable;
         pc_wake     <= {|pc_masked_change[23:16], |pc_masked_change[14:8],
                         |pc_masked_change[7:0]} & pc_enable;
      end
   end
endmodule // eiv_ext_irq

// ---- verif/eiv_ext_irq_monitor.sv ----
`timescale 1ns/10ps
module eiv_chk
#(
   parameter VEC_W = 14
)
(
   input wire             clock,
   input wire             rst,
   input wire [3:0]       addr,
   input wire [7:0]       wdata,
   input wire             wr,
   input wire             rd,
   input wire [7:0]       rdata,
   input wire [1:0]       ext_irq_pin,
   input wire             cpu_status_word_gie,
   input wire [VEC_W-1:0] boot_start_addr,
   input wire             app_side_boot_lock,
   input wire             exec_in_boot,
   input wire [VEC_W-1:0] vector_base,
   input wire [1:0]       take_ext,
   input wire [2:0]       take_pc,
   input wire [1:0]       level_wake,
   input wire             irq_blocked
);
   // app-side section lock condition seen at the ports
   wire lock_cond = (vector_base != 0) && app_side_boot_lock && !exec_in_boot;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   chk_sense_upper: assert property (
      $past(rd) && $past(addr) == 4'h1 |-> rdata[7:4] == 4'h0) else $error("sense upper nibble set");
   chk_vbase_value: assert property (
      vector_base == 0 || vector_base == boot_start_addr) else $error("vector base illegal");
   chk_gie_gate: assert property (
      !cpu_status_word_gie && !$past(cpu_status_word_gie) |-> take_ext == 2'b00 && take_pc == 3'b000)
      else $error("take without global enable");
   chk_block_take: assert property (
      irq_blocked && $past(irq_blocked) |-> take_ext == 2'b00 && take_pc == 3'b000)
      else $error("take while blocked");
   chk_unlock_hold: assert property (
      wr && addr == 4'h0 && wdata[0] |=> irq_blocked [*3]) else $error("unlock did not block");
   chk_vbase_move: assert property (
      $changed(vector_base) |-> $past(irq_blocked)) else $error("vector moved without unlock");
   chk_level_high: assert property (
      ext_irq_pin[0] [*5] |-> !level_wake[0]) else $error("level wake with pin high");
   chk_lock_block: assert property (
      $past(lock_cond) && lock_cond |-> irq_blocked) else $error("section lock not blocking");
endmodule // eiv_chk

bind eiv_ext_irq eiv_chk #(.VEC_W(VEC_W)) eiv_chk_i (.clock, .rst, .addr, .wdata, .wr, .rd, .rdata,
   .ext_irq_pin, .cpu_status_word_gie, .boot_start_addr, .app_side_boot_lock, .exec_in_boot,
   .vector_base, .take_ext, .take_pc, .level_wake, .irq_blocked);

// ---- verif/eiv_pins.sv ----
`timescale 1ns/10ps
module eiv_pins
#(
   parameter SKEW = 37
)
(
   input wire [1:0]    ext_req,
   input wire [23:0]   pc_req,
   output logic [1:0]  ext_irq_pin,
   output logic [23:0] pin_change_inputs
);
   // board levels land off the clock edge, so the design sees truly async edges
   initial ext_irq_pin = 2'b11;
   initial pin_change_inputs = 24'h00_0000;
   always @(ext_req) ext_irq_pin <= #SKEW ext_req;
   always @(pc_req) pin_change_inputs <= #SKEW pc_req;
endmodule // eiv_pins

// ---- verif/tb.sv ----
`timescale 1ns/10ps
module tb;
   localparam logic [13:0] BOOT = 14'h0c00;
   logic        clock, rst, wr, rd, gie, app_lock, boot_lock, in_boot, irq_blocked;
   logic [3:0]  addr;
   logic [7:0]  wdata, rdata, m0, m1, m2;
   logic [1:0]  ext_req, ack_ext, take_ext, level_wake, ext_pin;
   logic [2:0]  ack_pc, take_pc, pc_wake;
   logic [23:0] pc_req, pc_pin, tog;
   logic [13:0] vbase;
   logic [31:0] seed;
   int          mismatches, check_count, cycles;
   eiv_ext_irq #(.VEC_W(14)) eiv_ext_irq_i (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .ext_irq_pin(ext_pin), .pin_change_inputs(pc_pin),
      .cpu_status_word_gie(gie), .ack_ext(ack_ext), .ack_pc(ack_pc), .boot_start_addr(BOOT),
      .app_side_boot_lock(app_lock), .boot_side_boot_lock(boot_lock), .exec_in_boot(in_boot),
      .vector_base(vbase), .take_ext(take_ext), .take_pc(take_pc), .level_wake(level_wake),
      .pc_wake(pc_wake), .irq_blocked(irq_blocked));
   eiv_pins eiv_pins_i (.ext_req(ext_req), .pc_req(pc_req), .ext_irq_pin(ext_pin),
      .pin_change_inputs(pc_pin));
   function automatic logic [31:0] nx(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // pin-change flags expected from one toggle and the three masks
   function automatic logic [7:0] pcexp(logic [23:0] t, logic [7:0] a, b, c);
      return {5'b0, |(t[23:16] & c), |(t[14:8] & b[6:0]), |(t[7:0] & a)};
   endfunction
   // level mode never leaves a flag behind
   function automatic logic [7:0] exfl(logic [1:0] code);
      return (code == 2'b00) ? 8'h00 : 8'h03;
   endfunction
   task tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task cmp(string n, logic [15:0] e, logic [15:0] g);
      check_count++;
      if (g !== e)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // strobes are only ever set here, once per edge, so back-to-back is safe
   task bus(logic w, logic r, logic [3:0] a, logic [7:0] dv);
      wr <= w; rd <= r; addr <= a; wdata <= dv;
      @(posedge clock);
   endtask
   task wreg(logic [3:0] a, logic [7:0] dv);
      bus(1'b1, 1'b0, a, dv);
      bus(1'b0, 1'b0, a, dv);
   endtask
   task rchk(logic [3:0] a, logic [7:0] e);
      bus(1'b0, 1'b1, a, 8'h00);
      #1 cmp("rdata", e, rdata);
      bus(1'b0, 1'b0, 4'h0, 8'h00);
   endtask
   task cyc(int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   initial
   begin
      clock = 0;
      forever #50 clock = ~clock;
   end
   // hang guard, far above the few hundred cycles the run needs
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         mismatches++;
         tally_and_finish;
      end
   end
   initial
   begin
      rst = 1; wr = 0; rd = 0; addr = 0; wdata = 0; gie = 1; app_lock = 0; in_boot = 0; boot_lock = 0;
      ext_req = 2'b11; pc_req = 0; ack_ext = 0; ack_pc = 0; seed = 32'h31f2; cycles = 0;
      mismatches = 0; check_count = 0;
      repeat (20) @(posedge clock);
      rst <= 0;
      @(posedge clock);
      // status idles with both synced pins high
      for (int i = 0; i < 16; i++) rchk(i[3:0], (i == 9) ? 8'h18 : 8'h00);
      repeat (4)
      begin
         seed = nx(seed);
         wreg(4'h1, seed[7:0]);
         rchk(4'h1, seed[7:0] & 8'h0f);
      end
      $display("test registers done");
      wreg(4'h0, 8'h02);
      cyc(3); cmp("vbase", 0, vbase);
      bus(1'b1, 1'b0, 4'h0, 8'h01); bus(1'b1, 1'b0, 4'h0, 8'h02); bus(1'b0, 1'b0, 4'h0, 8'h00);
      cyc(2); cmp("vbase", BOOT, vbase);
      rchk(4'h0, 8'h02);
      app_lock <= 1; cyc(2); cmp("blocked", 1, irq_blocked);
      in_boot <= 1; cyc(2); cmp("blocked", 0, irq_blocked);
      app_lock <= 0; in_boot <= 0;
      wreg(4'h0, 8'h03); cyc(6); rchk(4'h0, 8'h02);
      wreg(4'h0, 8'h00); cyc(3); cmp("vbase", BOOT, vbase);
      bus(1'b1, 1'b0, 4'h0, 8'h03); bus(1'b1, 1'b0, 4'h0, 8'h00); bus(1'b0, 1'b0, 4'h0, 8'h00);
      cyc(3); cmp("vbase", 0, vbase);
      boot_lock <= 1; in_boot <= 1; cyc(2); cmp("blocked", 1, irq_blocked);
      boot_lock <= 0; in_boot <= 0; cyc(2);
      $display("test vectors done");
      wreg(4'h2, 8'h03);
      for (int k = 0; k < 4; k++)
      begin
         wreg(4'h1, {4'h0, k[1:0], k[1:0]});
         wreg(4'h3, 8'h03);
         ext_req <= 2'b00; cyc(3); ext_req <= 2'b11; cyc(8);
         rchk(4'h3, exfl(k[1:0]));
         cmp("take_ext", exfl(k[1:0]), take_ext);
         ack_ext <= 2'b11; cyc(1); ack_ext <= 2'b00; cyc(1);
         rchk(4'h3, 8'h00);
      end
      wreg(4'h1, 8'h00);
      ext_req <= 2'b10; cyc(6);
      cmp("level_wake", 2'b01, level_wake);
      cmp("take_ext", 2'b01, take_ext);
      gie <= 0; cyc(3); cmp("take_ext", 0, take_ext);
      gie <= 1; ext_req <= 2'b11; cyc(6); cmp("take_ext", 0, take_ext);
      $display("test ext pins done");
      wreg(4'h4, 8'h07);
      repeat (8)
      begin
         repeat (9) seed = nx(seed);
         m0 = seed[7:0]; m1 = seed[15:8]; m2 = seed[23:16];
         wreg(4'h6, m0); wreg(4'h7, m1); wreg(4'h8, m2);
         rchk(4'h7, m1 & 8'h7f);
         ack_pc <= 3'b111; cyc(1); ack_pc <= 3'b000;
         tog = 24'h00_0001 << (seed[31:24] % 24);
         pc_req <= pc_req ^ tog; cyc(3);
         cmp("pc_wake", pcexp(tog, m0, m1, m2) & 8'h07, pc_wake);
         cyc(5);
         rchk(4'h5, pcexp(tog, m0, m1, m2));
         cmp("take_pc", pcexp(tog, m0, m1, m2) & 8'h07, take_pc);
      end
      $display("test pin change done");
      tally_and_finish;
   end
endmodule // tb
